//--- design/ebpwm_defs.vh
`ifndef EBPWM_DEFS_VH
`define EBPWM_DEFS_VH

// register byte offsets
`define EBPWM_ADDR_W 12
`define EBPWM_OFF_CTRL 12'h000
`define EBPWM_OFF_DUTY 12'h004
`define EBPWM_OFF_DBRC 12'h008
`define EBPWM_OFF_SDC 12'h00c
`define EBPWM_OFF_STAT 12'h010

// capture_pwm_control fields
`define EBPWM_CTL_EN 0
`define EBPWM_CTL_POL_AC 1
`define EBPWM_CTL_POL_BD 2
`define EBPWM_CTL_MODE 5:4
`define EBPWM_CTL_MODE_HI 5
`define EBPWM_CTL_STEER 11:8

// duty register field
`define EBPWM_DUTY_F 9:0

// deadband_restart_control fields
`define EBPWM_DB_CNT 6:0
`define EBPWM_DB_ARS 7

// shutdown_control fields
`define EBPWM_SD_STAT 7
`define EBPWM_SD_SRC 6:4
`define EBPWM_SD_PAC 3:2
`define EBPWM_SD_PBD 1:0

// status register fields
`define EBPWM_ST_RUN 0
`define EBPWM_ST_DIR 1
`define EBPWM_ST_SRC 2
`define EBPWM_ST_RAW 3
`define EBPWM_ST_CHG 4

// output mode codes
`define EBPWM_MODE_SINGLE 2'b00
`define EBPWM_MODE_HALF 2'b10
`define EBPWM_MODE_FWD 2'b01
`define EBPWM_MODE_REV 2'b11

// reset values
`define EBPWM_RST_CTRL 12'h000
`define EBPWM_RST_DUTY 10'h000
`define EBPWM_RST_DBRC 8'h00
`define EBPWM_RST_SDC 8'h00
// sync flops idle: pin high, comparators low
`define EBPWM_RST_SYNC 3'h1

// timing
`define EBPWM_CYC_PER_INSN 4
`define EBPWM_DIR_LEAD 8'h04
// sub-count phase that lands the swap on a count boundary after two register stages
`define EBPWM_DIR_PHASE 2'b10
// source code -> {cmp2, cmp1, pin} enable mask, code 0 at low bits
`define EBPWM_SRC_MAP 24'hf5_9d10
// pair code -> {tristate, level}, code 0 at low bits
`define EBPWM_PSS_MAP 8'ha4

`endif

//--- design/ebpwm_bridge_out.v
// Operation
// - mode 00 single, 10 half, 01 fwd, 11 rev
// - single mode outputs follow steering enables
// - time base is timer count plus two bits
// - half-bridge: A is PWM, B complement
// - half-bridge outputs delayed by dead-band count
// - dead-band above duty keeps output inactive
// - forward: A active, D modulated, B C off
// - reverse: C active, B modulated, A D off
// - direction from upper mode bit, next cycle unless running full-bridge
// - direction change four counts before period end
// - no dead-band in full-bridge mode
// - shutdown from selected pin or comparator levels
// - shutdown status sticky until cleared or restarted
// - shutdown forces enabled outputs to their pair's selected states
// - shutdown level sensitive, persists with level
// - status writes ignored while condition present
// - restart only at next period start
// - writing one forces shutdown, auto-restart clears
// - auto-restart clears status once condition removed
// - first enable waits for new period
// - per-pair polarity from control bits 1 and 2
`timescale 1ns/1ps
`include "ebpwm_defs.vh"

module ebpwm_bridge_out #(
    parameter INSN_CYC = `EBPWM_CYC_PER_INSN,
    parameter [23:0] SRC_MAP = `EBPWM_SRC_MAP,
    parameter [7:0] PSS_MAP = `EBPWM_PSS_MAP
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // time base from the timer, same clock
    input wire [7:0] timer_count,
    input wire [1:0] timer_low_bits,
    input wire [7:0] period_register,
    // shutdown sources, asynchronous
    input wire shutdown_pin_n,
    input wire [1:0] comparator_output,
    // bridge outputs
    output wire output_a,
    output wire output_a_oe,
    output wire output_b,
    output wire output_b_oe,
    output wire output_c,
    output wire output_c_oe,
    output wire output_d,
    output wire output_d_oe
);

    // pair code lookup: {tristate, level}
    function [1:0] pss_state;
        input [1:0] code;
        begin
            pss_state = PSS_MAP[{code, 1'b0} +: 2];
        end
    endfunction

    // dead-band counter step
    function [6:0] db_step;
        input src;
        input tick;
        input [6:0] cnt;
        input [6:0] lim;
        begin
            if (!src)
                db_step = 7'h00;
            else if (tick && cnt < lim)
                db_step = cnt + 7'h01;
            else
                db_step = cnt;
        end
    endfunction

    reg [11:0] ctrl_r;
    reg [9:0] duty_r;
    reg [7:0] dbrc_r;
    reg [7:0] sdc_r;
    reg [2:0] sync1_r;
    reg [2:0] sync2_r;
    reg [9:0] tb_prev_r;
    reg raw_r;
    reg run_r;
    reg dir_r;
    reg chg_r;
    reg hold_r;
    reg [6:0] cnt_a_r;
    reg [6:0] cnt_b_r;
    reg [7:0] insn_r;
    reg [3:0] act_r;
    reg [3:0] oe_r;

    wire [9:0] time_base;
    wire period_start;
    wire wr_en;
    wire rd_en;
    wire addr_ok;
    wire [4:0] src_pos;
    wire [2:0] src_mask;
    wire [2:0] src_level;
    wire src_active;
    wire sd_write;
    wire sd_force;
    wire insn_tick;
    wire [1:0] mode;
    wire full_mode;
    wire [9:0] dir_point;
    wire [1:0] st_ac;
    wire [1:0] st_bd;
    wire [3:0] lvl_out;
    wire [3:0] oe_out;
    wire [3:0] pol;
    wire [3:0] sd_tri;
    wire [3:0] sd_lvl;
    reg [3:0] act_nxt;
    reg [3:0] oe_nxt;
    reg sd_stat_nxt;
    reg raw_nxt;

    // apb: zero wait states
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign addr_ok = (paddr == `EBPWM_OFF_CTRL) || (paddr == `EBPWM_OFF_DUTY) ||
                     (paddr == `EBPWM_OFF_DBRC) || (paddr == `EBPWM_OFF_SDC) ||
                     (paddr == `EBPWM_OFF_STAT);
    assign pslverr = psel & penable & ~addr_ok;
    assign sd_write = wr_en && (paddr == `EBPWM_OFF_SDC);

    always @* begin
        prdata = 32'h0000_0000;
        if (rd_en) begin
            case (paddr)
                `EBPWM_OFF_CTRL: prdata = {20'h00000, ctrl_r};
                `EBPWM_OFF_DUTY: prdata = {22'h0, duty_r};
                `EBPWM_OFF_DBRC: prdata = {24'h000000, dbrc_r};
                `EBPWM_OFF_SDC: prdata = {24'h000000, sdc_r};
                `EBPWM_OFF_STAT: prdata = {27'h0, chg_r, raw_r, src_active, dir_r, run_r};
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    assign mode = ctrl_r[`EBPWM_CTL_MODE];
    assign full_mode = mode[0];

    // time base and period edge
    assign time_base = {timer_count, timer_low_bits};
    assign period_start = (time_base == 10'h000) && (tb_prev_r != 10'h000);

    // instruction-cycle tick for dead-band
    assign insn_tick = (insn_r == INSN_CYC - 1);

    // shutdown sources
    // three mask bits per source code
    assign src_pos = {1'b0, sdc_r[`EBPWM_SD_SRC], 1'b0} + {2'b00, sdc_r[`EBPWM_SD_SRC]};
    assign src_mask = SRC_MAP[src_pos +: 3];
    assign src_level = {sync2_r[2], sync2_r[1], ~sync2_r[0]};
    assign src_active = |(src_mask & src_level);
    assign sd_force = sdc_r[`EBPWM_SD_STAT] | src_active | hold_r;

    // direction switch point, four counts before period end
    assign dir_point = {period_register - `EBPWM_DIR_LEAD, `EBPWM_DIR_PHASE};

    // raw pwm: set at period start, cleared at duty match
    always @* begin
        raw_nxt = raw_r;
        if (period_start)
            raw_nxt = (duty_r != 10'h000);
        else if (time_base == duty_r)
            raw_nxt = 1'b0;
    end

    always @* begin
        sd_stat_nxt = sdc_r[`EBPWM_SD_STAT];
        if (src_active)
            sd_stat_nxt = 1'b1;
        else if (dbrc_r[`EBPWM_DB_ARS])
            sd_stat_nxt = 1'b0;
        else if (sd_write)
            sd_stat_nxt = pwdata[`EBPWM_SD_STAT];
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `EBPWM_RST_CTRL;
            duty_r <= `EBPWM_RST_DUTY;
            dbrc_r <= `EBPWM_RST_DBRC;
            sdc_r <= `EBPWM_RST_SDC;
            sync1_r <= `EBPWM_RST_SYNC;
            sync2_r <= `EBPWM_RST_SYNC;
        end else begin
            sync1_r <= {comparator_output, shutdown_pin_n};
            sync2_r <= sync1_r;
            if (wr_en && paddr == `EBPWM_OFF_CTRL)
                ctrl_r <= pwdata[11:0];
            if (wr_en && paddr == `EBPWM_OFF_DUTY)
                duty_r <= pwdata[`EBPWM_DUTY_F];
            if (wr_en && paddr == `EBPWM_OFF_DBRC)
                dbrc_r <= pwdata[7:0];
            if (sd_write)
                sdc_r[6:0] <= pwdata[6:0];
            sdc_r[`EBPWM_SD_STAT] <= sd_stat_nxt;
        end
    end

    // time base, raw pwm, run, direction
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tb_prev_r <= 10'h000;
            raw_r <= 1'b0;
            run_r <= 1'b0;
            dir_r <= 1'b0;
            chg_r <= 1'b0;
            hold_r <= 1'b0;
            insn_r <= 8'h00;
        end else begin
            tb_prev_r <= time_base;
            // restart the instruction phase on each raw edge so the dead-band is exact
            insn_r <= (insn_tick || raw_nxt != raw_r) ? 8'h00 : insn_r + 8'h01;
            raw_r <= raw_nxt;
            if (!ctrl_r[`EBPWM_CTL_EN])
                run_r <= 1'b0;
            else if (period_start)
                run_r <= 1'b1;
            if (sdc_r[`EBPWM_SD_STAT] || src_active || (sd_write && pwdata[`EBPWM_SD_STAT]))
                hold_r <= 1'b1;
            else if (period_start)
                hold_r <= 1'b0;
            if (period_start)
                chg_r <= 1'b0;
            if (full_mode && (mode[1] != dir_r) && time_base == dir_point
                    && period_register >= `EBPWM_DIR_LEAD) begin
                dir_r <= mode[1];
                chg_r <= 1'b1;
            end else if (!full_mode || !run_r) begin
                dir_r <= mode[1];
            end
        end
    end

    // dead-band counters, run in every mode, read in half-bridge only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_a_r <= 7'h00;
            cnt_b_r <= 7'h00;
        end else begin
            cnt_a_r <= db_step(raw_r, insn_tick, cnt_a_r, dbrc_r[`EBPWM_DB_CNT]);
            cnt_b_r <= db_step(~raw_r, insn_tick, cnt_b_r, dbrc_r[`EBPWM_DB_CNT]);
        end
    end

    // active levels per mode
    always @* begin
        act_nxt = 4'h0;
        oe_nxt = 4'h0;
        if (ctrl_r[`EBPWM_CTL_EN]) begin
            case (mode)
                `EBPWM_MODE_SINGLE: begin
                    oe_nxt = ctrl_r[`EBPWM_CTL_STEER];
                    act_nxt = {4{raw_r & run_r}} & ctrl_r[`EBPWM_CTL_STEER];
                end
                `EBPWM_MODE_HALF: begin
                    oe_nxt = 4'h3;
                    // a source that falls before the count completes stays off
                    act_nxt[0] = run_r & raw_r & (cnt_a_r >= dbrc_r[`EBPWM_DB_CNT]);
                    act_nxt[1] = run_r & ~raw_r & (cnt_b_r >= dbrc_r[`EBPWM_DB_CNT]);
                end
                default: begin
                    oe_nxt = 4'hf;
                    if (!dir_r) begin
                        act_nxt[0] = run_r;
                        act_nxt[3] = run_r & raw_r & ~chg_r;
                    end else begin
                        act_nxt[2] = run_r;
                        act_nxt[1] = run_r & raw_r & ~chg_r;
                    end
                end
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_r <= 4'h0;
            oe_r <= 4'h0;
        end else begin
            act_r <= act_nxt;
            oe_r <= oe_nxt;
        end
    end

    // polarity and shutdown override, order {d, c, b, a}
    assign pol = {ctrl_r[`EBPWM_CTL_POL_BD], ctrl_r[`EBPWM_CTL_POL_AC],
                  ctrl_r[`EBPWM_CTL_POL_BD], ctrl_r[`EBPWM_CTL_POL_AC]};
    assign st_ac = pss_state(sdc_r[`EBPWM_SD_PAC]);
    assign st_bd = pss_state(sdc_r[`EBPWM_SD_PBD]);
    assign sd_tri = {st_bd[1], st_ac[1], st_bd[1], st_ac[1]};
    assign sd_lvl = {st_bd[0], st_ac[0], st_bd[0], st_ac[0]};
    assign lvl_out = sd_force ? sd_lvl : (act_r ^ pol);
    assign oe_out = sd_force ? (oe_r & ~sd_tri) : oe_r;

    assign output_a = lvl_out[0];
    assign output_b = lvl_out[1];
    assign output_c = lvl_out[2];
    assign output_d = lvl_out[3];
    assign output_a_oe = oe_out[0];
    assign output_b_oe = oe_out[1];
    assign output_c_oe = oe_out[2];
    assign output_d_oe = oe_out[3];

endmodule // ebpwm_bridge_out

//--- tb/ebpwm_pins.sv
`timescale 1ns/1ps
module ebpwm_pins (
    // levels and enables from the bridge
    input wire [3:0] lv,
    input wire [3:0] oe,
    // pin levels seen by the switch drivers
    output wire [3:0] pin
);
    // released pins rest on the board pull-downs
    assign pin = oe & lv;
endmodule // ebpwm_pins

//--- tb/ebpwm_bridge_out_chk.sv
`timescale 1ns/1ps
module ebpwm_bridge_out_chk #(parameter INSN_CYC = 4) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // time base and sources
    input wire [7:0] timer_count,
    input wire [1:0] timer_low_bits,
    input wire [7:0] period_register,
    input wire shutdown_pin_n,
    input wire [1:0] comparator_output,
    // bridge outputs
    input wire output_a,
    input wire output_a_oe,
    input wire output_b,
    input wire output_b_oe,
    input wire output_c,
    input wire output_c_oe,
    input wire output_d,
    input wire output_d_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    reg [11:0] ctl_r;
    reg [7:0] sdc_r;
    reg [5:0] calm_r;
    wire wr = psel && penable && pwrite;
    wire rd_sdc = psel && penable && !pwrite && paddr == 12'h00c;
    // settled: enabled, no writes and no sources for a long while
    wire run = calm_r == 6'h3f && ctl_r[0] && !sdc_r[7];
    wire [1:0] m = ctl_r[5:4];
    wire ac_ok = sdc_r[3] ? !output_a_oe && !output_c_oe :
        output_a_oe && output_c_oe && output_a == sdc_r[2] && output_c == sdc_r[2];
    wire bd_ok = sdc_r[1] ? !output_b_oe && !output_d_oe :
        output_b_oe && output_d_oe && output_b == sdc_r[0] && output_d == sdc_r[0];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_r <= 12'h0;
            sdc_r <= 8'h0;
            calm_r <= 6'h0;
        end else begin
            if (wr && paddr == 12'h000)
                ctl_r <= pwdata[11:0];
            if (wr && paddr == 12'h00c)
                sdc_r <= pwdata[7:0];
            if (wr || !shutdown_pin_n || comparator_output != 2'h0)
                calm_r <= 6'h0;
            else if (calm_r != 6'h3f)
                calm_r <= calm_r + 6'h1;
        end
    end
    sequence pin_sd_s;
        (!shutdown_pin_n && sdc_r[6] && ctl_r[0] && ctl_r[4]) [*3];
    endsequence
    idle_rdata_a: assert property (!(psel && penable) |-> prdata == 32'h0)
        else $error("read data outside access");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access");
    steer_oe_a: assert property (run && m == 2'h0 |->
        {output_d_oe, output_c_oe, output_b_oe, output_a_oe} == ctl_r[11:8])
        else $error("steering enables wrong");
    half_cd_a: assert property (run && m == 2'h2 |-> !output_c_oe && !output_d_oe)
        else $error("half mode drives c or d");
    half_excl_a: assert property (run && m == 2'h2 |->
        !((output_a ^ ctl_r[1]) && (output_b ^ ctl_r[2])))
        else $error("half mode a and b both active");
    fwd_pins_a: assert property (run && m == 2'h1 |->
        (output_a ^ ctl_r[1]) && !(output_b ^ ctl_r[2]) && !(output_c ^ ctl_r[1]))
        else $error("forward levels wrong");
    rev_pins_a: assert property (run && m == 2'h3 |->
        (output_c ^ ctl_r[1]) && !(output_a ^ ctl_r[1]) && !(output_d ^ ctl_r[2]))
        else $error("reverse levels wrong");
    sd_force_a: assert property (pin_sd_s |-> ac_ok && bd_ok)
        else $error("shutdown states wrong");
    sd_stat_a: assert property (pin_sd_s ##1 (!shutdown_pin_n && rd_sdc) |-> prdata[7])
        else $error("shutdown status not set");
endmodule // ebpwm_bridge_out_chk
bind ebpwm_bridge_out ebpwm_bridge_out_chk #(.INSN_CYC(INSN_CYC)) ebpwm_bridge_out_chk_i (.*);

//--- tb/test_ebpwm_bridge_out.sv
`timescale 1ns/1ps
module test_ebpwm_bridge_out;
    reg pclk, presetn, psel, penable, pwrite, shutdown_pin_n, se;
    reg [11:0] paddr;
    reg [31:0] pwdata, rd, hc;
    reg [7:0] timer_count;
    reg [1:0] timer_low_bits, comparator_output;
    wire [31:0] prdata;
    wire pready, pslverr;
    wire [3:0] lv, oe, pin;
    integer miscompares, n_tests, cyc, i;
    ebpwm_bridge_out ebpwm_bridge_out_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_count(timer_count), .timer_low_bits(timer_low_bits), .period_register(8'h07),
        .shutdown_pin_n(shutdown_pin_n), .comparator_output(comparator_output),
        .output_a(lv[0]), .output_a_oe(oe[0]), .output_b(lv[1]), .output_b_oe(oe[1]),
        .output_c(lv[2]), .output_c_oe(oe[2]), .output_d(lv[3]), .output_d_oe(oe[3]));
    ebpwm_pins ebpwm_pins_i (.lv(lv), .oe(oe), .pin(pin));
    initial begin
        pclk = 1'h0;
        forever #4 pclk = ~pclk;
    end
    // 32-step time base, timer period 7
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        {timer_count, timer_low_bits} <= ({timer_count, timer_low_bits} == 10'h01f) ? 10'h000 :
            {timer_count, timer_low_bits} + 10'h001;
        if (cyc == 3000) begin
            miscompares = miscompares + 1;
            wrap_up;
        end
    end
    task wrap_up;
        begin
            $display("compares %0d miscompares %0d", n_tests, miscompares);
            if (miscompares == 0 && n_tests > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                miscompares = miscompares + 1;
                $display("ERROR %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            psel <= 1'h1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'h1;
            @(posedge pclk);
            while (pready !== 1'h1)
                @(posedge pclk);
            rd = prdata;
            se = pslverr;
            psel <= 1'h0;
            penable <= 1'h0;
            @(posedge pclk);
        end
    endtask
    task rdc(input [11:0] a, input [31:0] e);
        begin
            apb(1'h0, a, 32'h0);
            chk("rdata", e, rd);
        end
    endtask
    task wt(input [7:0] v);
        while (timer_count !== v)
            @(posedge pclk);
    endtask
    // settle, then count high cycles of each pin over one period
    task cnt(input [31:0] e);
        begin
            hc = 32'h0;
            repeat (70) @(posedge pclk);
            for (i = 0; i < 32; i = i + 1) begin
                @(posedge pclk);
                hc = hc + {7'h0, pin[3], 7'h0, pin[2], 7'h0, pin[1], 7'h0, pin[0]};
            end
            chk("count", e, hc);
        end
    endtask
    task t_regs;
        begin
            chk("oe", 32'h0, {28'h0, oe});
            for (i = 0; i < 20; i = i + 4)
                rdc(i[11:0], 32'h0);
            apb(1'h0, 12'h020, 32'h0);
            chk("slverr", 32'h1, {31'h0, se});
            chk("rdata", 32'h0, rd);
        end
    endtask
    task t_single;
        begin
            apb(1'h1, 12'h004, 32'h10);
            apb(1'h1, 12'h000, 32'h501);
            cnt(32'h0010_0010);
            chk("oe", 32'h5, {28'h0, oe});
        end
    endtask
    task t_half;
        begin
            apb(1'h1, 12'h000, 32'h21);
            apb(1'h1, 12'h008, 32'h2);
            cnt(32'h0000_0808);
            apb(1'h1, 12'h008, 32'h7f);
            cnt(32'h0);
        end
    endtask
    task t_full;
        begin
            apb(1'h1, 12'h000, 32'h11);
            cnt(32'h1000_0020);
            wt(8'h00);
            apb(1'h1, 12'h000, 32'h31);
            wt(8'h02);
            chk("pins", 32'h9, {28'h0, pin});
            wt(8'h06);
            chk("pins", 32'h4, {28'h0, pin});
            rdc(12'h010, 32'h13);
            apb(1'h1, 12'h000, 32'h33);
            cnt(32'h0000_1020);
        end
    endtask
    task t_sd;
        begin
            apb(1'h1, 12'h000, 32'h11);
            apb(1'h1, 12'h00c, 32'h46);
            shutdown_pin_n <= 1'h0;
            repeat (4) @(posedge pclk);
            chk("pins", 32'h55, {24'h0, oe, pin});
            apb(1'h1, 12'h00c, 32'h46);
            rdc(12'h00c, 32'hc6);
            shutdown_pin_n <= 1'h1;
            repeat (4) @(posedge pclk);
            wt(8'h00);
            apb(1'h1, 12'h00c, 32'h46);
            rdc(12'h00c, 32'h46);
            wt(8'h06);
            chk("pins", 32'h55, {24'h0, oe, pin});
            cnt(32'h1000_0020);
        end
    endtask
    task t_ar;
        begin
            apb(1'h1, 12'h008, 32'h80);
            rdc(12'h008, 32'h80);
            apb(1'h1, 12'h00c, 32'h16);
            comparator_output <= 2'h1;
            repeat (4) @(posedge pclk);
            rdc(12'h00c, 32'h96);
            comparator_output <= 2'h0;
            repeat (4) @(posedge pclk);
            rdc(12'h00c, 32'h16);
            wt(8'h01);
            apb(1'h1, 12'h00c, 32'h96);
            chk("pins", 32'h55, {24'h0, oe, pin});
            rdc(12'h00c, 32'h16);
        end
    endtask
    initial begin
        miscompares = 0;
        n_tests = 0;
        cyc = 0;
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        {timer_count, timer_low_bits} = 10'h0;
        shutdown_pin_n = 1'h1;
        comparator_output = 2'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        t_regs;
        t_single;
        t_half;
        t_full;
        t_sd;
        t_ar;
        wrap_up;
    end
endmodule // test_ebpwm_bridge_out
